// ==== src/alr_pkg.sv ====
// alarm low limit register bank: constants, register map and link encodings
// assumes a 16-bit command word per frame, address in [15:9], write flag in [8]
package alr_pkg;

  // ----------------------------------------------------------------
  // channel count and frame layout
  // ----------------------------------------------------------------
  localparam int         NUM_CH       = 8;
  localparam int         LIM_W        = 16;
  localparam int         ADDR_HI      = 15;
  localparam int         ADDR_LO      = 9;
  localparam int         WR_BIT       = 8;
  localparam int         CMD_HI       = 15;
  localparam int         CMD_LO       = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_LT_MSB0 = 7'h18;
  localparam logic [6:0] ADDR_LT_LSB0 = 7'h19;
  localparam logic [6:0] ADDR_STRIDE  = 7'h05;
  localparam logic [6:0] ADDR_ECHO    = 7'h3F;

  // ----------------------------------------------------------------
  // reset values and fixed fields
  // ----------------------------------------------------------------
  localparam logic [7:0] LT_MSB_RST   = 8'h00;
  localparam logic [3:0] LT_NIB_RST   = 4'h0;
  localparam logic [7:0] ECHO_RST     = 8'h00;
  localparam logic [3:0] NIB_ZERO     = 4'h0;
  localparam logic [7:0] PAD_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // link edge counts
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_LAST_IN  = 5'h0F;
  localparam logic [4:0] CNT_LOAD     = 5'h10;
  localparam logic [3:0] TAIL_FROM    = 4'h8;
  localparam logic [3:0] NSH_LAST     = 4'hF;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_DONE  = 3'b100
  } alr_tx_e;

endpackage : alr_pkg

// ==== src/alr_regs.sv ====
// alarm low limit registers and command echo behind a serial link
// assumes the host is an spi master: data in on rising sclk, out on falling sclk
`timescale 1ns/10ps

module alr_regs
  import alr_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    sdi,
  output logic                         sdo,
  output logic                         sdo_oe,
  output logic [NUM_CH*LIM_W-1:0]      chan_low_alarm_limit
);

  // ----------------------------------------------------------------
  // state types, one per clocked block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]              cnt;
    logic [14:0]             sin;
  } alr_frame_s;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0]  msb;
    logic [NUM_CH-1:0][3:0]  nib;
    logic [15:0]             last;
    logic [7:0]              prev;
    logic                    wr_tgl;
  } alr_link_s;

  typedef struct packed {
    alr_tx_e                 st;
    logic [15:0]             sh;
    logic [3:0]              nsh;
    logic                    sdo;
    logic                    oe;
  } alr_tx_s;

  typedef struct packed {
    logic                    t1;
    logic                    t2;
    logic                    t3;
    logic [NUM_CH-1:0][15:0] lim;
  } alr_mc_s;

  alr_frame_s              fr_q;
  alr_frame_s              fr_d;
  alr_link_s               lk_q;
  alr_link_s               lk_d;
  alr_tx_s                 tx_q;
  alr_tx_s                 tx_d;
  alr_mc_s                 mc_q;
  alr_mc_s                 mc_d;

  logic                    frame_rst_n;
  logic [15:0]             word;
  logic [6:0]              waddr;
  logic                    wflag;
  logic                    fin;
  logic [6:0]              raddr;
  logic                    rflag;
  logic [7:0]              rd;
  logic                    load_echo;
  logic [NUM_CH-1:0]       hit_wm;
  logic [NUM_CH-1:0]       hit_wn;
  logic [NUM_CH-1:0]       hit_rm;
  logic [NUM_CH-1:0]       hit_rn;

  // a raised chip select clears the frame logic without an sclk edge,
  // so a host that stops early leaves nothing half-shifted behind
  assign frame_rst_n = rstn & ~cs_n;

  // ----------------------------------------------------------------
  // per-channel address decode
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam logic [6:0] A_M = 7'(ADDR_LT_MSB0 + 7'(g) * ADDR_STRIDE);
      localparam logic [6:0] A_N = 7'(ADDR_LT_LSB0 + 7'(g) * ADDR_STRIDE);
      assign hit_wm[g] = (waddr == A_M);
      assign hit_wn[g] = (waddr == A_N);
      assign hit_rm[g] = (raddr == A_M);
      assign hit_rn[g] = (raddr == A_N);
    end
  endgenerate

  // ----------------------------------------------------------------
  // frame counter and input shifter, rising sclk
  // ----------------------------------------------------------------
  always_comb begin
    fr_d = fr_q;
    fr_d.sin = {fr_q.sin[13:0], sdi};
    if (fr_q.cnt != CNT_LOAD) begin
      fr_d.cnt = fr_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  // ----------------------------------------------------------------
  // register bank and command history, rising sclk
  // ----------------------------------------------------------------
  // kept on the link clock: a read answer is due one half sclk period
  // after the word completes, far too soon for a crossing to mclk
  always_comb begin
    word  = {fr_q.sin, sdi};
    waddr = word[ADDR_HI:ADDR_LO];
    wflag = word[WR_BIT];
    fin   = (fr_q.cnt == CNT_LAST_IN);
    lk_d  = lk_q;
    if (fin) begin
      lk_d.last = word;
      lk_d.prev = lk_q.last[CMD_HI:CMD_LO];
      if (wflag && ((hit_wm | hit_wn) != '0)) begin
        lk_d.wr_tgl = ~lk_q.wr_tgl;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (wflag && hit_wm[i]) begin
          lk_d.msb[i] = word[7:0];
        end
        if (wflag && hit_wn[i]) begin
          lk_d.nib[i] = word[7:4];
        end
      end
      // a write to the echo address matches no entry and is dropped
    end
  end

  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      lk_q.msb    <= {NUM_CH{LT_MSB_RST}};
      lk_q.nib    <= {NUM_CH{LT_NIB_RST}};
      lk_q.last   <= '0;
      lk_q.prev   <= ECHO_RST;
      lk_q.wr_tgl <= 1'b0;
    end else begin
      lk_q <= lk_d;
    end
  end

  a_msb_write: assert property (@(posedge sclk) disable iff (!rstn)
    (fin && wflag && waddr == ADDR_LT_MSB0) |=> (lk_q.msb[0] == $past(word[7:0])))
    else $error("upper limit byte not written");

  a_nib_write: assert property (@(posedge sclk) disable iff (!rstn)
    (fin && wflag && waddr == ADDR_LT_LSB0) |=> (lk_q.nib[0] == $past(word[7:4])))
    else $error("limit nibble not written");

  a_ro_ignore: assert property (@(posedge sclk) disable iff (!rstn)
    (fin && waddr == ADDR_ECHO) |=> ($stable(lk_q.msb) && $stable(lk_q.nib)))
    else $error("echo address access changed a limit");

  a_echo_prev: assert property (@(posedge sclk) disable iff (!rstn)
    fin |=> (lk_q.prev == $past(lk_q.last[CMD_HI:CMD_LO])))
    else $error("echo does not hold previous command");

  // ----------------------------------------------------------------
  // output shifter, falling sclk
  // ----------------------------------------------------------------
  always_comb begin
    raddr = lk_q.last[ADDR_HI:ADDR_LO];
    rflag = lk_q.last[WR_BIT];
    rd    = 8'h00;
    if (raddr == ADDR_ECHO) begin
      rd = lk_q.prev;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit_rm[i]) begin
        rd = lk_q.msb[i];
      end
      if (hit_rn[i]) begin
        rd = {lk_q.nib[i], NIB_ZERO};
      end
    end
    if (rflag) begin
      rd = 8'h00;
    end
    load_echo = (tx_q.st == TX_IDLE) && (fr_q.cnt == CNT_LOAD) && (raddr == ADDR_ECHO) && !rflag;
  end

  always_comb begin
    tx_d = tx_q;
    case (tx_q.st)
      TX_IDLE: begin
        if (fr_q.cnt == CNT_LOAD) begin
          tx_d.st  = TX_SHIFT;
          tx_d.sh  = {rd, PAD_ZERO};
          tx_d.nsh = 4'h0;
          tx_d.sdo = rd[7];
          tx_d.oe  = 1'b1;
        end
      end
      TX_SHIFT: begin
        tx_d.sh  = {tx_q.sh[14:0], 1'b0};
        tx_d.nsh = tx_q.nsh + 4'h1;
        tx_d.sdo = tx_q.sh[14];
        if (tx_q.nsh == NSH_LAST) begin
          tx_d.st  = TX_DONE;
          tx_d.sdo = 1'b0;
        end
      end
      TX_DONE: begin
        tx_d.sdo = 1'b0;
      end
      default: begin
        tx_d.st  = TX_IDLE;
        tx_d.sdo = 1'b0;
        tx_d.oe  = 1'b0;
      end
    endcase
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_q.st  <= TX_IDLE;
      tx_q.sh  <= '0;
      tx_q.nsh <= 4'h0;
      tx_q.sdo <= 1'b0;
      tx_q.oe  <= 1'b0;
    end else begin
      tx_q <= tx_d;
    end
  end

  assign sdo    = tx_q.sdo;
  assign sdo_oe = tx_q.oe;

  a_echo_first: assert property (@(negedge sclk) disable iff (!frame_rst_n)
    load_echo |=> (tx_q.sdo == $past(lk_q.prev[7])) && tx_q.oe)
    else $error("echo msb not driven at 16th falling edge");

  a_echo_order: assert property (@(negedge sclk) disable iff (!frame_rst_n)
    load_echo |-> ##2 (tx_q.sdo == lk_q.prev[6]))
    else $error("echo second bit out of order");

  a_tail_zero: assert property (@(negedge sclk) disable iff (!frame_rst_n)
    (tx_q.st == TX_SHIFT && tx_q.nsh >= TAIL_FROM) |-> !tx_q.sdo)
    else $error("echo pad bits not zero");

  a_oe_quiet: assert property (@(negedge sclk) disable iff (!frame_rst_n)
    (tx_q.st == TX_IDLE) |-> (!tx_q.oe && !tx_q.sdo))
    else $error("sdo driven before 16th falling edge");

  // ----------------------------------------------------------------
  // limit mirror on mclk
  // ----------------------------------------------------------------
  // the toggle passes two flops; the limits are copied one cycle later,
  // when they have been stable for at least two mclk cycles. the next write can
  // only land sixteen sclk edges on, so the copy never sees a changing word
  always_comb begin
    mc_d    = mc_q;
    mc_d.t1 = lk_q.wr_tgl;
    mc_d.t2 = mc_q.t1;
    mc_d.t3 = mc_q.t2;
    if (mc_q.t2 != mc_q.t3) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mc_d.lim[i] = {lk_q.msb[i], lk_q.nib[i], NIB_ZERO};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mc_q.t1  <= 1'b0;
      mc_q.t2  <= 1'b0;
      mc_q.t3  <= 1'b0;
      mc_q.lim <= {NUM_CH{LT_MSB_RST, LT_NIB_RST, NIB_ZERO}};
    end else begin
      mc_q <= mc_d;
    end
  end

  assign chan_low_alarm_limit = mc_q.lim;

  a_nib_zero: assert property (@(posedge mclk) disable iff (!rstn)
    (mc_q.lim[0][3:0] == NIB_ZERO) && (mc_q.lim[NUM_CH-1][3:0] == NIB_ZERO))
    else $error("limit low bits not zero");

  a_limit_form: assert property (@(posedge mclk) disable iff (!rstn)
    (mc_q.t2 != mc_q.t3) |=> (mc_q.lim[0] == {$past(lk_q.msb[0]), $past(lk_q.nib[0]), NIB_ZERO}))
    else $error("limit word badly formed");

endmodule : alr_regs

// ==== testbench/alr_host.sv ====
// spi host model for the serial link of the alarm limit register bank
// assumes sclk idles low; the device samples on rising and drives on falling sclk
`timescale 1ns/10ps
module alr_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // ----------------------------------------------------------------
  // one frame of n sclk cycles; the clock stands still outside frames
  // ----------------------------------------------------------------
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rx, output logic [1:0] oe);
    rx   = 16'h0000;
    oe   = 2'b00;
    cs_n = 1'b0;
    // a count of 24 ends an echo read early
    for (int i = 0; i < n; i++) begin
      // past the command bits sdi toggles so a stale level never passes for data
      sdi = (i < 16) ? w[15-i] : ~sdi;
      #6 sclk = 1'b1;
      if (i == 15) oe[1] = sdo_oe;
      if (i == 16) oe[0] = sdo_oe;
      if (i >= 16) rx[31-i] = sdo;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    sdi = ~sdi;
    #6;
  endtask : frame
endmodule : alr_host

// ==== testbench/alr_regs_tb.sv ====
// self-checking bench for the alarm limit register bank
// assumes the host model drives the link and mclk runs at 8 ns
`timescale 1ns/10ps
module alr_regs_tb
  import alr_pkg::*;
;
  logic                    mclk, rstn, sclk, cs_n, sdi, sdo, sdo_oe;
  logic [NUM_CH*LIM_W-1:0] chan_low_alarm_limit;
  logic [7:0]              m_exp [NUM_CH];
  logic [7:0]              l_exp [NUM_CH];
  logic [15:0]             lf;
  int                      n_mismatch, compares;

  alr_regs dut (.mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
                .sdo_oe(sdo_oe), .chan_low_alarm_limit(chan_low_alarm_limit));
  alr_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt

  function automatic logic [15:0] exp_lim(input logic [7:0] m, input logic [7:0] l);
    return {m, l[7:4], NIB_ZERO};
  endfunction : exp_lim

  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] rx;
    logic [1:0]  oe;
    u_host.frame({a, 1'b1, d}, 16, rx, oe);
  endtask : wr

  task automatic wr_ch(input int ch, input logic [7:0] m, input logic [7:0] l);
    wr(ADDR_LT_MSB0 + 7'(ch) * ADDR_STRIDE, m);
    wr(ADDR_LT_LSB0 + 7'(ch) * ADDR_STRIDE, l);
    m_exp[ch] = m;
    l_exp[ch] = l;
  endtask : wr_ch

  task automatic rdc(input logic [6:0] a, input int n, input logic [15:0] exp);
    logic [15:0] rx;
    logic [1:0]  oe;
    lf = nxt(lf);
    u_host.frame({a, 1'b0, lf[7:0]}, n, rx, oe);
    chk(rx, exp, "read answer");
    chk({14'h0000, oe}, 16'h0001, "sdo_oe start");
    chk({15'h0000, sdo_oe}, 16'h0000, "sdo_oe after frame");
  endtask : rdc

  // mirror settles in about 3 mclk cycles; 10 leaves margin
  task automatic chk_bus();
    repeat (10) @(posedge mclk);
    for (int ch = 0; ch < NUM_CH; ch++) begin
      chk(chan_low_alarm_limit[16*ch +: 16], exp_lim(m_exp[ch], l_exp[ch]), "limit mirror");
    end
  endtask : chk_bus

  task automatic do_reset();
    @(posedge mclk);
    #1 rstn = 1'b0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      m_exp[ch] = 8'h00;
      l_exp[ch] = 8'h00;
    end
    repeat (6) @(posedge mclk);
    #1 rstn = 1'b1;
  endtask : do_reset
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [6:0] a;
    rstn       = 1'b0;
    lf         = 16'hCEF7;
    n_mismatch = 0;
    compares   = 0;
    do_reset();
    chk_bus();
    rdc(ADDR_ECHO, 32, 16'h0000);
    wr_ch(0, 8'hAA, 8'hFF);
    chk_bus();
    rdc(ADDR_LT_MSB0, 32, 16'hAA00);
    rdc(ADDR_LT_LSB0, 32, 16'hF000);
    for (int k = 0; k < 3; k++) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        lf = nxt(lf);
        a  = ADDR_LT_LSB0 + 7'(ch) * ADDR_STRIDE;
        wr_ch(ch, lf[15:8], lf[7:0]);
        rdc(ADDR_ECHO, 24, {a, 1'b1, 8'h00});
        rdc(ADDR_ECHO, 32, {ADDR_ECHO, 1'b0, 8'h00});
        rdc(a, 32, {l_exp[ch][7:4], 4'h0, 8'h00});
        rdc(ADDR_LT_MSB0 + 7'(ch) * ADDR_STRIDE, 32, {m_exp[ch], 8'h00});
      end
      chk_bus();
    end
    wr(7'h3D, lf[7:0]);
    wr(7'h10, lf[15:8]);
    wr(ADDR_ECHO, 8'hFF);
    chk_bus();
    rdc(7'h3D, 32, 16'h0000);
    do_reset();
    chk_bus();
    rdc(ADDR_ECHO, 32, 16'h0000);
    rdc(ADDR_LT_MSB0, 32, 16'h0000);
    close_out();
  end

  // the run needs about 50 us; a hang is cut at 300 us
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end
endmodule : alr_regs_tb
